// >>> hdl/dtcp_timers.sv
`timescale 1ns/1ps

// How it works
// R1 - Divider select gives /12, /4, /48, ext/8
// R2 - Clock bit 3 picks timer 1 system clock
// R3 - Clock bit 2 picks timer 0 system clock
// R4 - Clock bits 5,4 exported for timer 2
// R5 - Clock bits 7,6 exported for timer 3
// R6 - Counter select counts falling pin edges
// R7 - Count needs run bit and gate condition
// R8 - 13-bit mode uses high byte, low five
// R9 - 13-bit rollover sets overflow flag
// R10 - Run bit never clears the count
// R11 - Software preloads count before running
// R12 - 16-bit mode counts all sixteen bits
// R13 - Auto-reload copies high byte on rollover
// R14 - Split low byte uses timer 0 controls
// R15 - Split high byte runs on timer 1 bits
// R16 - Split hides timer 1 pin and flag
// R17 - Split runs timer 1 by mode alone
// R18 - Timer 1 mode 3 holds count
// R19 - Both timers configured independently, same modes 0 to 2
// R20 - Interrupt request needs its enable bit
// R21 - Mode field encodes 13/16/reload/split
// R22 - Timer 1 gates on external input one
// R23 - Flag cleared by software or vectoring
// R24 - Pins synchronised and edge detected
// R25 - Clock control resets to zero
module dtcp_timers (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // Pins
  input  wire logic       timer0_event_pin,
  input  wire logic       timer1_event_pin,
  input  wire logic       ext_osc_clk,
  input  wire logic       ext_irq_zero_input,
  input  wire logic       ext_irq_one_input,
  // Interrupt controller side
  input  wire logic       ext_irq_zero_polarity,
  input  wire logic       ext_irq_one_polarity,
  input  wire logic       timer0_irq_enable,
  input  wire logic       timer1_irq_enable,
  input  wire logic       timer0_isr_ack,
  input  wire logic       timer1_isr_ack,
  output logic            timer0_irq,
  output logic            timer1_irq,
  // Consumers of the timer 1 overflow and the timer 2/3 clock choices
  output logic            timer1_overflow_pulse,
  output logic            timer2_high_byte_clock_sel,
  output logic            timer2_low_byte_clock_sel,
  output logic            timer3_high_byte_clock_sel,
  output logic            timer3_low_byte_clock_sel
);

  typedef struct packed {
    logic [7:0] timer_clock_control;
    logic [7:0] timer_mode_reg;
    logic       timer0_overflow_flag;
    logic       timer1_overflow_flag;
    logic       timer0_run;
    logic       timer1_run;
    logic [3:0] irq_cfg;
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic [5:0] presc_cnt;
    logic [2:0] ext_cnt;
    logic       presc_tick;
    logic [7:0] rdata;
    logic       irq0;
    logic       irq1;
    logic       t1_ovf;
  } dtcp_state_type;

  dtcp_state_type s;
  dtcp_state_type next_s;
  logic [1:0]     rst_pipe;
  logic           rst_sync_n;
  logic           t0_pin_fall;
  logic           t1_pin_fall;
  logic           ext_rise;
  logic           ext_irq_zero_input_level;
  logic           ext_irq_one_input_level;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  dtcp_edge_sync u_t0_pin ( // R24
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (timer0_event_pin),
    .level      (),
    .fall       (t0_pin_fall),
    .rise       ()
  );

  dtcp_edge_sync u_t1_pin ( // R24
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (timer1_event_pin),
    .level      (),
    .fall       (t1_pin_fall),
    .rise       ()
  );

  dtcp_edge_sync u_ext_osc (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (ext_osc_clk),
    .level      (),
    .fall       (),
    .rise       (ext_rise)
  );

  dtcp_edge_sync u_ext_irq_zero_input (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (ext_irq_zero_input),
    .level      (ext_irq_zero_input_level),
    .fall       (),
    .rise       ()
  );

  dtcp_edge_sync u_ext_irq_one_input (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (ext_irq_one_input),
    .level      (ext_irq_one_input_level),
    .fall       (),
    .rise       ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // One count step for modes 13-bit, 16-bit and auto-reload.
  // Returns {overflow, high byte, low byte}.

  function automatic logic [16:0] count_step(input logic [1:0] m,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h1;
    c16 = {1'b0, hi, lo} + 17'h1;
    c8  = {1'b0, lo} + 9'h1;
    case (m)
      dtcp_pkg::MODE_13BIT: begin
        // The three upper low-byte bits are left as they were.
        count_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // R8 R9
      end
      dtcp_pkg::MODE_16BIT: begin
        count_step = c16; // R12
      end
      default: begin
        if (c8[8]) begin
          count_step = {1'b1, hi, hi}; // R13
        end else begin
          count_step = {1'b0, hi, c8[7:0]};
        end
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic [1:0]  div_sel;
  logic [1:0]  m0;
  logic [1:0]  m1;
  logic        split;
  logic        t0_tick;
  logic        th0_tick;
  logic        t1_tick;
  logic        t0_en;
  logic        t1_en;
  logic        ext_irq_zero_input_active;
  logic        ext_irq_one_input_active;
  logic        set0;
  logic        set1;
  logic        t1_wrap;
  logic [5:0]  presc_last;
  logic [16:0] r0;
  logic [16:0] r1;
  logic [8:0]  th0_inc;

  always_comb begin
    next_s      = s;
    div_sel     = s.timer_clock_control[dtcp_pkg::CK_DIV_HI:
                                        dtcp_pkg::CK_DIV_LO];
    m0          = s.timer_mode_reg[dtcp_pkg::MD_T0_MHI:dtcp_pkg::MD_T0_MLO];
    m1          = s.timer_mode_reg[dtcp_pkg::MD_T1_MHI:dtcp_pkg::MD_T1_MLO];
    split       = (m0 == dtcp_pkg::MODE_SPLIT); // R21
    set0        = 1'b0;
    set1        = 1'b0;
    t1_wrap     = 1'b0;
    r0          = '0;
    r1          = '0;
    th0_inc     = '0;
    presc_last  = dtcp_pkg::DIV12_LAST;
    next_s.t1_ovf     = 1'b0;
    next_s.presc_tick = 1'b0;

    // Prescaler; the tick is registered, so it lags one cycle behind.
    case (div_sel) // R1
      dtcp_pkg::DIV_SEL_4:  presc_last = dtcp_pkg::DIV4_LAST;
      dtcp_pkg::DIV_SEL_48: presc_last = dtcp_pkg::DIV48_LAST;
      default:              presc_last = dtcp_pkg::DIV12_LAST;
    endcase
    if (div_sel == dtcp_pkg::DIV_SEL_EXT) begin
      if (ext_rise) begin
        if (s.ext_cnt == dtcp_pkg::EXT8_LAST) begin
          next_s.ext_cnt    = '0;
          next_s.presc_tick = 1'b1; // R1
        end else begin
          next_s.ext_cnt = s.ext_cnt + 3'h1;
        end
      end
    end else if (s.presc_cnt >= presc_last) begin
      next_s.presc_cnt  = '0;
      next_s.presc_tick = 1'b1; // R1
    end else begin
      next_s.presc_cnt = s.presc_cnt + 6'h1;
    end

    // Timebases and enables.
    ext_irq_zero_input_active = (ext_irq_zero_input_level == ext_irq_zero_polarity);
    ext_irq_one_input_active = (ext_irq_one_input_level == ext_irq_one_polarity); // R22
    if (s.timer_mode_reg[dtcp_pkg::MD_T0_CNT]) begin
      t0_tick = t0_pin_fall; // R6
    end else if (s.timer_clock_control[dtcp_pkg::CK_T0_SYS]) begin
      t0_tick = 1'b1; // R3
    end else begin
      t0_tick = s.presc_tick;
    end
    th0_tick = s.timer_clock_control[dtcp_pkg::CK_T0_SYS] | s.presc_tick;
    if (s.timer_mode_reg[dtcp_pkg::MD_T1_CNT] && !split) begin
      t1_tick = t1_pin_fall; // R6 R16
    end else if (s.timer_clock_control[dtcp_pkg::CK_T1_SYS]) begin
      t1_tick = 1'b1; // R2
    end else begin
      t1_tick = s.presc_tick;
    end
    t0_en = s.timer0_run &&
            (!s.timer_mode_reg[dtcp_pkg::MD_T0_GATE] || ext_irq_zero_input_active); // R7
    if (split) begin
      t1_en = (m1 != dtcp_pkg::MODE_SPLIT); // R17
    end else begin
      t1_en = s.timer1_run && (m1 != dtcp_pkg::MODE_SPLIT) &&
              (!s.timer_mode_reg[dtcp_pkg::MD_T1_GATE] || ext_irq_one_input_active);
    end

    // Timer 0. Counting resumes from the stored bytes (R10).
    if (t0_en && t0_tick) begin // R19
      if (split) begin
        r0 = count_step(dtcp_pkg::MODE_RELOAD, 8'h00,
                        s.timer0_low_byte); // R14
        if (r0[16]) begin
          r0[7:0] = 8'h00;
        end
        next_s.timer0_low_byte = r0[7:0];
        set0 = r0[16];
      end else begin
        r0 = count_step(m0, s.timer0_high_byte, s.timer0_low_byte);
        next_s.timer0_high_byte = r0[15:8];
        next_s.timer0_low_byte  = r0[7:0];
        set0 = r0[16];
      end
    end
    if (split && s.timer1_run && th0_tick) begin
      th0_inc = {1'b0, s.timer0_high_byte} + 9'h1; // R15
      next_s.timer0_high_byte = th0_inc[7:0];
      set1 = th0_inc[8];
    end

    // Timer 1; mode 3 leaves it frozen.
    if (t1_en && t1_tick) begin // R18 R19
      r1 = count_step(m1, s.timer1_high_byte, s.timer1_low_byte);
      next_s.timer1_high_byte = r1[15:8];
      next_s.timer1_low_byte  = r1[7:0];
      t1_wrap = r1[16];
    end
    next_s.t1_ovf = t1_wrap; // R16
    if (!split) begin
      set1 = t1_wrap;
    end

    // Register writes; software takes a byte over any count step.
    if (sfr_wr) begin
      case (sfr_addr)
        dtcp_pkg::ADDR_CLOCK_CTRL: next_s.timer_clock_control = sfr_wdata;
        dtcp_pkg::ADDR_MODE:       next_s.timer_mode_reg = sfr_wdata;
        dtcp_pkg::ADDR_T0_LOW:     next_s.timer0_low_byte = sfr_wdata;
        dtcp_pkg::ADDR_T0_HIGH:    next_s.timer0_high_byte = sfr_wdata;
        dtcp_pkg::ADDR_T1_LOW:     next_s.timer1_low_byte = sfr_wdata;
        dtcp_pkg::ADDR_T1_HIGH:    next_s.timer1_high_byte = sfr_wdata;
        dtcp_pkg::ADDR_RUN_FLAG: begin
          next_s.timer0_run = sfr_wdata[dtcp_pkg::RF_T0_RUN]; // R10
          next_s.timer1_run = sfr_wdata[dtcp_pkg::RF_T1_RUN];
          next_s.irq_cfg    = sfr_wdata[dtcp_pkg::RF_CFG_HI:
                                        dtcp_pkg::RF_CFG_LO];
        end
        default: begin
        end
      endcase
    end

    // Flags: vectoring or a write may clear, but a new overflow wins.
    if (timer0_isr_ack) begin
      next_s.timer0_overflow_flag = 1'b0; // R23
    end
    if (timer1_isr_ack) begin
      next_s.timer1_overflow_flag = 1'b0; // R23
    end
    if (sfr_wr && sfr_addr == dtcp_pkg::ADDR_RUN_FLAG) begin
      next_s.timer0_overflow_flag = sfr_wdata[dtcp_pkg::RF_T0_FLAG];
      next_s.timer1_overflow_flag = sfr_wdata[dtcp_pkg::RF_T1_FLAG];
    end
    if (set0) begin
      next_s.timer0_overflow_flag = 1'b1; // R9
    end
    if (set1) begin
      next_s.timer1_overflow_flag = 1'b1; // R15
    end
    next_s.irq0 = next_s.timer0_overflow_flag & timer0_irq_enable; // R20
    next_s.irq1 = next_s.timer1_overflow_flag & timer1_irq_enable; // R20

    // Reads return the state before this cycle's update.
    if (sfr_rd) begin
      case (sfr_addr)
        dtcp_pkg::ADDR_CLOCK_CTRL: next_s.rdata = s.timer_clock_control;
        dtcp_pkg::ADDR_MODE:       next_s.rdata = s.timer_mode_reg;
        dtcp_pkg::ADDR_T0_LOW:     next_s.rdata = s.timer0_low_byte;
        dtcp_pkg::ADDR_T0_HIGH:    next_s.rdata = s.timer0_high_byte;
        dtcp_pkg::ADDR_T1_LOW:     next_s.rdata = s.timer1_low_byte;
        dtcp_pkg::ADDR_T1_HIGH:    next_s.rdata = s.timer1_high_byte;
        dtcp_pkg::ADDR_RUN_FLAG: begin
          next_s.rdata = {s.timer1_overflow_flag, s.timer1_run,
                          s.timer0_overflow_flag, s.timer0_run, s.irq_cfg};
        end
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s                     <= '0;
      s.timer_clock_control <= dtcp_pkg::CLOCK_CTRL_RESET; // R25
      s.timer_mode_reg      <= dtcp_pkg::MODE_RESET;
      s.irq_cfg             <= dtcp_pkg::IRQ_CFG_RESET;
      s.timer0_low_byte     <= dtcp_pkg::BYTE_RESET;
      s.timer0_high_byte    <= dtcp_pkg::BYTE_RESET;
      s.timer1_low_byte     <= dtcp_pkg::BYTE_RESET;
      s.timer1_high_byte    <= dtcp_pkg::BYTE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata             = s.rdata;
  assign timer0_irq            = s.irq0;
  assign timer1_irq            = s.irq1;
  assign timer1_overflow_pulse = s.t1_ovf;
  assign timer2_high_byte_clock_sel =
    s.timer_clock_control[dtcp_pkg::CK_T2_HIGH]; // R4
  assign timer2_low_byte_clock_sel =
    s.timer_clock_control[dtcp_pkg::CK_T2_LOW]; // R4
  assign timer3_high_byte_clock_sel =
    s.timer_clock_control[dtcp_pkg::CK_T3_HIGH]; // R5
  assign timer3_low_byte_clock_sel =
    s.timer_clock_control[dtcp_pkg::CK_T3_LOW]; // R5

endmodule

// >>> hdl/dtcp_pkg.sv
package dtcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the special-function register port.
  localparam logic [7:0] ADDR_RUN_FLAG   = 8'h88;
  localparam logic [7:0] ADDR_MODE       = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW     = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW     = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH    = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH    = 8'h8d;
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h8e;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [3:0] IRQ_CFG_RESET    = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock-control field positions.
  localparam int CK_T3_HIGH = 7;
  localparam int CK_T3_LOW  = 6;
  localparam int CK_T2_HIGH = 5;
  localparam int CK_T2_LOW  = 4;
  localparam int CK_T1_SYS  = 3;
  localparam int CK_T0_SYS  = 2;
  localparam int CK_DIV_HI  = 1;
  localparam int CK_DIV_LO  = 0;

  // Run/flag register field positions.
  localparam int RF_T1_FLAG = 7;
  localparam int RF_T1_RUN  = 6;
  localparam int RF_T0_FLAG = 5;
  localparam int RF_T0_RUN  = 4;
  localparam int RF_CFG_HI  = 3;
  localparam int RF_CFG_LO  = 0;

  // Mode register field positions.
  localparam int MD_T1_GATE = 7;
  localparam int MD_T1_CNT  = 6;
  localparam int MD_T1_MHI  = 5;
  localparam int MD_T1_MLO  = 4;
  localparam int MD_T0_GATE = 3;
  localparam int MD_T0_CNT  = 2;
  localparam int MD_T0_MHI  = 1;
  localparam int MD_T0_MLO  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Mode field encodings.
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // Divider selections.
  localparam logic [1:0] DIV_SEL_12  = 2'h0;
  localparam logic [1:0] DIV_SEL_4   = 2'h1;
  localparam logic [1:0] DIV_SEL_48  = 2'h2;
  localparam logic [1:0] DIV_SEL_EXT = 2'h3;

  // Terminal counts of the prescaler, one below each divisor.
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [2:0] EXT8_LAST  = 3'h7;

  localparam logic [4:0] LOW5_ONES = 5'h1f;

endpackage

// >>> hdl/dtcp_edge_sync.sv
`timescale 1ns/1ps

// Brings an asynchronous pin into the clock domain and flags its edges.
module dtcp_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_sync_n,
  // Pin
  input  wire logic pin,
  // Synchronised view
  output logic      level,
  output logic      fall,
  output logic      rise
);

  typedef struct packed {
    logic first;
    logic second;
    logic third;
  } dtcp_sync_type;

  dtcp_sync_type s;
  dtcp_sync_type next_s;

  always_comb begin
    next_s        = s;
    next_s.first  = pin;
    next_s.second = s.first;
    next_s.third  = s.second;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // The first stage feeds only the second, so a metastable value never
  // reaches the edge logic.
  assign level = s.second;
  assign fall  = s.third & ~s.second;
  assign rise  = s.second & ~s.third;

endmodule

// >>> verification/dtcp_pins_model.sv
`timescale 1ns/1ps

// Stands in for the parts outside the pins: event pulses, gates, oscillator.
module dtcp_pins_model (
  // Control from the bench
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] n_falls,
  input  wire logic       timer0_gating,
  input  wire logic       timer1_gating,
  // Pins
  output logic            timer0_event_pin,
  output logic            timer1_event_pin,
  output logic            ext_osc_clk,
  output logic            ext_irq_zero_input,
  output logic            ext_irq_one_input,
  output logic            busy
);
  assign ext_irq_zero_input = timer0_gating;
  assign ext_irq_one_input  = timer1_gating;

  // The oscillator runs free at 25 MHz, unrelated in phase to clk.
  initial begin
    ext_osc_clk = 1'b0;
    #3;
    forever #20 ext_osc_clk = ~ext_osc_clk;
  end

  // Each level is held three cycles, so the sampler never misses one.
  initial begin
    timer0_event_pin = 1'b1;
    timer1_event_pin = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      repeat (n_falls) begin
        repeat (3) @(negedge clk);
        timer0_event_pin = 1'b0;
        timer1_event_pin = 1'b0;
        repeat (3) @(negedge clk);
        timer0_event_pin = 1'b1;
        timer1_event_pin = 1'b1;
      end
      busy = 1'b0;
    end
  end
endmodule

// >>> verification/dtcp_timers_assertions.sv
`timescale 1ns/1ps

module dtcp_timers_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  // Interrupt side
  input wire logic       timer0_irq_enable,
  input wire logic       timer0_isr_ack,
  input wire logic       timer0_irq,
  // Exported signals
  input wire logic       timer1_overflow_pulse,
  input wire logic       timer2_high_byte_clock_sel,
  input wire logic       timer2_low_byte_clock_sel,
  input wire logic       timer3_high_byte_clock_sel,
  input wire logic       timer3_low_byte_clock_sel
);
  logic [1:0] t1_mode;
  logic       t0_run;
  logic [3:0] sels;
  logic       ck_wr;
  logic       rf_wr;

  assign sels = {timer3_high_byte_clock_sel, timer3_low_byte_clock_sel,
                 timer2_high_byte_clock_sel, timer2_low_byte_clock_sel};
  assign ck_wr = sfr_wr && sfr_addr == dtcp_pkg::ADDR_CLOCK_CTRL;
  assign rf_wr = sfr_wr && sfr_addr == dtcp_pkg::ADDR_RUN_FLAG;

  // Shadows of software-owned bits, so a flag set cannot race the check.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t1_mode <= 2'h0;
      t0_run  <= 1'b0;
    end else begin
      if (sfr_wr && sfr_addr == dtcp_pkg::ADDR_MODE)
        t1_mode <= sfr_wdata[5:4];
      if (rf_wr)
        t0_run <= sfr_wdata[4];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_irq0_enable: assert property (
    !timer0_irq_enable |=> !timer0_irq) else $error("irq without enable");
  chk_soft_set: assert property (
    rf_wr && sfr_wdata[5] && timer0_irq_enable |=> timer0_irq)
    else $error("irq missing after flag set");
  chk_ack_clear: assert property (
    timer0_isr_ack && !t0_run && !sfr_wr |=> !timer0_irq)
    else $error("flag not cleared by ack");
  chk_t2_export: assert property (
    ck_wr |=> sels[1:0] == $past(sfr_wdata[5:4]))
    else $error("timer2 clock choice wrong");
  chk_t3_export: assert property (
    ck_wr |=> sels[3:2] == $past(sfr_wdata[7:6]))
    else $error("timer3 clock choice wrong");
  chk_sel_hold: assert property (
    !ck_wr |=> $stable(sels)) else $error("clock choice moved");
  chk_reset_zero: assert property (
    $rose(rst_n) |-> sels == 4'h0 && !timer0_irq && !timer1_overflow_pulse)
    else $error("outputs not zero after reset");
  chk_t1_mode3: assert property (
    t1_mode == 2'h3 && $past(t1_mode) == 2'h3 |-> !timer1_overflow_pulse)
    else $error("timer1 wrapped in mode 3");
endmodule

bind dtcp_timers dtcp_timers_chk u_chk (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .timer0_irq_enable(timer0_irq_enable),
  .timer0_isr_ack(timer0_isr_ack), .timer0_irq(timer0_irq),
  .timer1_overflow_pulse(timer1_overflow_pulse),
  .timer2_high_byte_clock_sel(timer2_high_byte_clock_sel),
  .timer2_low_byte_clock_sel(timer2_low_byte_clock_sel),
  .timer3_high_byte_clock_sel(timer3_high_byte_clock_sel),
  .timer3_low_byte_clock_sel(timer3_low_byte_clock_sel)
);

// >>> verification/tb_dtcp_timers.sv
`timescale 1ns/1ps

module tb_dtcp_timers;
  logic       clk, rst_n, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic       timer0_event_pin, timer1_event_pin, ext_osc_clk;
  logic       ext_irq_zero_input, ext_irq_one_input;
  logic       ext_irq_zero_polarity, ext_irq_one_polarity;
  logic       timer0_irq_enable, timer1_irq_enable;
  logic       timer0_isr_ack, timer1_isr_ack, timer0_irq, timer1_irq;
  logic       timer1_overflow_pulse, timer2_high_byte_clock_sel;
  logic       timer2_low_byte_clock_sel, timer3_high_byte_clock_sel;
  logic       timer3_low_byte_clock_sel, go, timer0_gating, timer1_gating, busy;
  logic [3:0] n_falls;
  int         n_errors, tests_run;

  dtcp_timers uut (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .timer0_event_pin, .timer1_event_pin, .ext_osc_clk,
    .ext_irq_zero_input, .ext_irq_one_input, .ext_irq_zero_polarity,
    .ext_irq_one_polarity, .timer0_irq_enable, .timer1_irq_enable,
    .timer0_isr_ack, .timer1_isr_ack, .timer0_irq, .timer1_irq,
    .timer1_overflow_pulse, .timer2_high_byte_clock_sel,
    .timer2_low_byte_clock_sel, .timer3_high_byte_clock_sel,
    .timer3_low_byte_clock_sel);
  dtcp_pins_model pins (.clk, .go, .n_falls, .timer0_gating, .timer1_gating,
    .timer0_event_pin, .timer1_event_pin, .ext_osc_clk,
    .ext_irq_zero_input, .ext_irq_one_input, .busy);

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  // Which: 0 timer0 irq, 1 timer1 irq, 2 timer1 wrap, 3 pins idle.
  task automatic wait_for(input int which);
    int   i;
    logic hit;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      hit = which == 0 ? timer0_irq : which == 1 ? timer1_irq :
            which == 2 ? timer1_overflow_pulse : !busy;
      if (hit === 1'b1)
        break;
    end
    if (i == 400) begin
      n_errors++;
      $display("wrong value at %0t: wait timed out", $time);
      conclude();
    end
  endtask

  task automatic pulse(input logic [3:0] n);
    n_falls = n;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    wait_for(3);
    repeat (6) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a;
    for (a = 8'h88; a <= 8'h8e; a++) begin
      rd(a, v);
      check(v, 8'h00);
    end
    wr(8'h8e, 8'ha5);
    rd(8'h8e, v);
    check(v, 8'ha5);
    check({4'h0, timer3_high_byte_clock_sel, timer3_low_byte_clock_sel,
      timer2_high_byte_clock_sel, timer2_low_byte_clock_sel}, 8'h0a);
    rd(8'h90, v);
    check(v, 8'h00);
    wr(8'h8e, 8'h00);
  endtask

  // Both timers, every prescale choice and the system clock, 200 cycles.
  task automatic t_rate();
    int         ex [5] = '{16, 50, 4, 5, 200};
    logic [7:0] ck;
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 5; i++) begin
        ck = i == 4 ? 8'h04 << t : 8'(i);
        wr(8'h89, 8'h01 << (4 * t));
        wr(8'h8e, ck);
        wr(8'(8'h8a + t), 8'h00);
        wr(8'(8'h8c + t), 8'h00);
        wr(8'h88, 8'h10 << (2 * t));
        repeat (199) @(negedge clk);
        wr(8'h88, 8'h00);
        rd(8'(8'h8a + t), v);
        check(8'(v + 1 >= ex[i] && v <= ex[i] + 1), 8'h01);
      end
    end
  endtask

  task automatic t_ovf13();
    wr(8'h89, 8'h00);
    wr(8'h8e, 8'h04);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'h1d);
    wr(8'h88, 8'h10);
    wait_for(0);
    wr(8'h88, 8'h20);
    rd(8'h8c, v);
    check(v, 8'h00);
    rd(8'h8a, v);
    check(8'((v & 8'h1f) < 8'h10), 8'h01);
    timer0_isr_ack = 1'b1;
    @(negedge clk);
    timer0_isr_ack = 1'b0;
    check(8'(timer0_irq), 8'h00);
    rd(8'h88, v);
    check(v, 8'h00);
    timer0_irq_enable = 1'b0;
    wr(8'h88, 8'h20);
    check(8'(timer0_irq), 8'h00);
    timer0_irq_enable = 1'b1;
    repeat (2) @(negedge clk);
    check(8'(timer0_irq), 8'h01);
    wr(8'h88, 8'h00);
  endtask

  task automatic t_reload();
    wr(8'h89, 8'h20);
    wr(8'h8e, 8'h08);
    wr(8'h8d, 8'hf0);
    wr(8'h8b, 8'hfd);
    wr(8'h88, 8'h40);
    wait_for(2);
    wr(8'h88, 8'h80);
    check(8'(timer1_irq), 8'h01);
    timer1_isr_ack = 1'b1;
    @(negedge clk);
    timer1_isr_ack = 1'b0;
    check(8'(timer1_irq), 8'h00);
    rd(8'h8d, v);
    check(v, 8'hf0);
    rd(8'h8b, v);
    check(8'(v >= 8'hf0 && v < 8'hfd), 8'h01);
    wr(8'h88, 8'h00);
  endtask

  // System-clock selects are set but ignored while counting pin edges.
  task automatic t_count();
    wr(8'h89, 8'hdd);
    wr(8'h8e, 8'h0c);
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h00);
    timer0_gating = 1'b1;
    wr(8'h88, 8'h50);
    pulse(4'h4);
    rd(8'h8a, v);
    check(v, 8'h04);
    rd(8'h8b, v);
    check(v, 8'h00);
    wr(8'h88, 8'h00);
    pulse(4'h2);
    ext_irq_one_polarity = 1'b0;
    wr(8'h88, 8'h50);
    pulse(4'h3);
    rd(8'h8a, v);
    check(v, 8'h07);
    rd(8'h8b, v);
    check(v, 8'h03);
    wr(8'h88, 8'h00);
  endtask

  task automatic t_split();
    logic [7:0] hold;
    wr(8'h89, 8'h03);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'h1c);
    wait_for(2);
    @(negedge clk);
    check(8'(timer1_irq), 8'h00);
    rd(8'h88, v);
    check(v, 8'h00);
    rd(8'h8c, v);
    check(v, 8'h00);
    wr(8'h89, 8'h33);
    rd(8'h8b, hold);
    repeat (20) @(negedge clk);
    rd(8'h8b, v);
    check(v, hold);
    wr(8'h8c, 8'hfc);
    wr(8'h88, 8'h40);
    wait_for(1);
    rd(8'h8a, v);
    check(v, 8'h00);
    wr(8'h88, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    ext_irq_zero_polarity = 1'b1;
    ext_irq_one_polarity = 1'b1;
    timer0_irq_enable = 1'b1;
    timer1_irq_enable = 1'b1;
    timer0_isr_ack = 1'b0;
    timer1_isr_ack = 1'b0;
    go = 1'b0;
    n_falls = 4'h0;
    timer0_gating = 1'b0;
    timer1_gating = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_rate();
    t_ovf13();
    t_reload();
    t_count();
    t_split();
    conclude();
  end
endmodule
